// *** bench/otp_fuse_model.sv ***
`timescale 1ns/1ps
module otp_fuse_model #(
   parameter logic [7:0] DELAY_IMAGE = 8'h43,
   parameter logic [7:0] CONFIG_IMAGE = 8'h48
) (
   output seq_cfg_pkg::otp_image_t otp_image
);
   // Programmed memory holds its defaults as static levels.
   assign otp_image = {DELAY_IMAGE, CONFIG_IMAGE};
endmodule

// *** bench/tb_seq_cfg_regs.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
   $display("BAD %0t got %h want %h", $time, a, e); end end
module tb_seq_cfg_regs;
   localparam logic [7:0] DLY = 8'h43;
   localparam logic [7:0] CFG = 8'h48;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   seq_cfg_pkg::reg_req_t reg_req = '0;
   seq_cfg_pkg::otp_image_t otp_image;
   seq_cfg_pkg::pulldown_t pulldowns;
   logic [7:0] reg_rdata;
   logic enable_inputs = 1'b0;
   logic half_delay = 1'b0;
   logic third_general_output;
   logic thermal_warning_threshold_select;
   logic otp_reload;
   logic serial_if_reset;
   int err_count = 0;
   int check_count = 0;
   int n1;
   int n2;

   otp_fuse_model #(.DELAY_IMAGE(DLY), .CONFIG_IMAGE(CFG)) otp_u (
      .otp_image(otp_image)
   );

   seq_cfg_regs #(.TICK_CYCLES(10)) dut_u (
      .core_clk(core_clk),
      .rstn(rstn),
      .reg_req(reg_req),
      .reg_rdata(reg_rdata),
      .otp_image(otp_image),
      .enable_inputs(enable_inputs),
      .half_delay(half_delay),
      .third_general_output(third_general_output),
      .pulldowns(pulldowns),
      .thermal_warning_threshold_select(thermal_warning_threshold_select),
      .otp_reload(otp_reload),
      .serial_if_reset(serial_if_reset)
   );

   always #5 core_clk = ~core_clk;

   task automatic stop_test();
      $display("errors=%0d checks=%0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1};
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_req.addr <= a;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(reg_rdata, e)
   endtask

   task automatic chk_cfg(input logic [7:0] v);
      `CHK(pulldowns, {v[6], v[4], v[2], v[1]})
      `CHK(thermal_warning_threshold_select, v[3])
   endtask

   // Counts cycles from the pin change to the output reaching the level;
   // two extra cycles cover the synchroniser and the edge detector.
   task automatic seq(input logic lvl, input int exp);
      int n;
      n = 0;
      @(posedge core_clk);
      enable_inputs <= lvl;
      @(posedge core_clk);
      #1;
      while (third_general_output !== lvl && n < 300) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      `CHK(n, exp + 2)
   endtask

   initial begin
      #100us;
      err_count++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(8'h17, DLY);
      rd(8'h19, CFG);
      chk_cfg(CFG);
      rd(8'h18, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'h19, 8'h5E);
      rd(8'h19, 8'h5E);
      chk_cfg(8'h5E);
      wr(8'h19, 8'hA1);
      rd(8'h19, 8'hA1);
      chk_cfg(8'hA1);
      wr(8'h17, 8'h21);
      wr(8'h19, 8'h00);
      seq(1'b1, 20);
      seq(1'b0, 40);
      wr(8'h19, 8'h80);
      seq(1'b1, 40);
      seq(1'b0, 80);
      wr(8'h19, 8'h00);
      @(posedge core_clk);
      half_delay <= 1'b1;
      seq(1'b1, 10);
      @(posedge core_clk);
      half_delay <= 1'b0;
      wr(8'h17, 8'h00);
      seq(1'b0, 0);
      wr(8'h18, 8'h01);
      n1 = 0;
      n2 = 0;
      repeat (5) begin
         @(posedge core_clk);
         #1;
         if (otp_reload === 1'b1) n1++;
         if (serial_if_reset === 1'b1) n2++;
      end
      `CHK(n1, 1)
      `CHK(n2, 1)
      rd(8'h18, 8'h00);
      rd(8'h17, DLY);
      rd(8'h19, CFG);
      chk_cfg(CFG);
      stop_test();
   end
endmodule

// *** rtl/half_ms_tick.sv ***
`timescale 1ns/1ps
`include "seq_cfg_regs.svh"
module half_ms_tick #(
   parameter int unsigned TICK_CYCLES = `HALF_MS_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic restart,
   output logic tick
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;

   // Restarting on the enable edge makes each delay start from a full tick.
   always_comb begin
      if (restart || cnt_reg == TICK_CYCLES - 1) begin
         cnt_next = 32'h00000000;
      end else begin
         cnt_next = cnt_reg + 32'h00000001;
      end
   end

   assign tick = !restart && (cnt_reg == TICK_CYCLES - 1);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 32'h00000000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

// *** rtl/seq_cfg_pkg.sv ***
package seq_cfg_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
   } reg_req_t;
   typedef struct packed {
      logic sync_clk;
      logic en3;
      logic en2;
      logic en1;
   } pulldown_t;
   typedef struct packed {
      logic [7:0] out3_delay;
      logic [7:0] config_val;
   } otp_image_t;
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_RISE = 3'b010,
      SEQ_FALL = 3'b100
   } seq_state_t;
endpackage

// *** rtl/seq_cfg_regs.sv ***
`timescale 1ns/1ps
`include "seq_cfg_regs.svh"
module seq_cfg_regs #(
   parameter int unsigned TICK_CYCLES = `HALF_MS_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input seq_cfg_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input seq_cfg_pkg::otp_image_t otp_image,
   input wire logic enable_inputs,
   input wire logic half_delay,
   output logic third_general_output,
   output seq_cfg_pkg::pulldown_t pulldowns,
   output logic thermal_warning_threshold_select,
   output logic otp_reload,
   output logic serial_if_reset
);
   logic [7:0] out3_delay_reg, out3_delay_next;
   logic [7:0] restart_reg, restart_next;
   logic [7:0] config_reg, config_next;
   logic load_pending_reg, load_pending_next;
   logic [7:0] rdata_reg, rdata_next;
   logic otp_reload_reg, serial_reset_reg;
   logic en_s1_reg, en_s2_reg, en_s3_reg;
   logic rise_edge, fall_edge, tick;
   seq_cfg_pkg::seq_state_t state_reg, state_next;
   logic [6:0] count_reg, count_next;
   logic out_reg, out_next;

   // Delay counted in half-millisecond ticks.
   function automatic logic [6:0] delay_units(input logic [3:0] code,
                                              input logic dbl,
                                              input logic half);
      logic [6:0] c;
      c = {3'h0, code};
      if (dbl && !half) begin
         delay_units = c << 2;
      end else if (half && !dbl) begin
         delay_units = c;
      end else begin
         delay_units = c << 1;
      end
   endfunction

   // Register file and restart sequencing.
   always_comb begin
      out3_delay_next = out3_delay_reg;
      restart_next = restart_reg;
      config_next = config_reg;
      load_pending_next = 1'b0;
      if (load_pending_reg || restart_reg[`POS_RESTART]) begin
         out3_delay_next = otp_image.out3_delay;
         config_next = otp_image.config_val;
         restart_next = `RST_RESTART;
      end else if (reg_req.wr) begin
         unique case (reg_req.addr)
            `OFS_OUT3_DELAY: out3_delay_next = reg_req.wdata;
            `OFS_RESTART: restart_next = reg_req.wdata;
            `OFS_CONFIG: config_next = reg_req.wdata;
            default: ;
         endcase
      end
      unique case (reg_req.addr)
         `OFS_OUT3_DELAY: rdata_next = out3_delay_reg;
         `OFS_RESTART: rdata_next = restart_reg;
         `OFS_CONFIG: rdata_next = config_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         out3_delay_reg <= `RST_OUT3_DELAY;
         restart_reg <= `RST_RESTART;
         config_reg <= `RST_CONFIG;
         load_pending_reg <= 1'b1;
         rdata_reg <= 8'h00;
         otp_reload_reg <= 1'b0;
         serial_reset_reg <= 1'b0;
      end else begin
         out3_delay_reg <= out3_delay_next;
         restart_reg <= restart_next;
         config_reg <= config_next;
         load_pending_reg <= load_pending_next;
         rdata_reg <= rdata_next;
         otp_reload_reg <= restart_reg[`POS_RESTART];
         serial_reset_reg <= restart_reg[`POS_RESTART];
      end
   end

   assign reg_rdata = rdata_reg;
   assign otp_reload = otp_reload_reg;
   assign serial_if_reset = serial_reset_reg;
   assign pulldowns = '{
      sync_clk: config_reg[`POS_SYNC_PD],
      en3: config_reg[`POS_EN3_PULL],
      en2: config_reg[`POS_EN2_PULL],
      en1: config_reg[`POS_EN1_PULL]
   };
   assign thermal_warning_threshold_select = config_reg[`POS_THERM_SEL];

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_s1_reg <= 1'b0;
         en_s2_reg <= 1'b0;
         en_s3_reg <= 1'b0;
      end else begin
         en_s1_reg <= enable_inputs;
         en_s2_reg <= en_s1_reg;
         en_s3_reg <= en_s2_reg;
      end
   end

   assign rise_edge = en_s2_reg && !en_s3_reg;
   assign fall_edge = !en_s2_reg && en_s3_reg;

   half_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .core_clk(core_clk),
      .rstn(rstn),
      .restart(rise_edge || fall_edge),
      .tick(tick)
   );

   // Sequencer: a new edge always aborts a pending opposite transition.
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      out_next = out_reg;
      if (rise_edge) begin
         count_next = delay_units(out3_delay_reg[`POS_RISE_DELAY +: 4],
                                  config_reg[`POS_DOUBLE], half_delay);
         if (count_next == 7'h00) begin
            out_next = 1'b1;
            state_next = seq_cfg_pkg::SEQ_IDLE;
         end else begin
            state_next = seq_cfg_pkg::SEQ_RISE;
         end
      end else if (fall_edge) begin
         count_next = delay_units(out3_delay_reg[`POS_FALL_DELAY +: 4],
                                  config_reg[`POS_DOUBLE], half_delay);
         if (count_next == 7'h00) begin
            out_next = 1'b0;
            state_next = seq_cfg_pkg::SEQ_IDLE;
         end else begin
            state_next = seq_cfg_pkg::SEQ_FALL;
         end
      end else if (tick && state_reg != seq_cfg_pkg::SEQ_IDLE) begin
         count_next = count_reg - 7'h01;
         if (count_reg == 7'h01) begin
            out_next = (state_reg == seq_cfg_pkg::SEQ_RISE);
            state_next = seq_cfg_pkg::SEQ_IDLE;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= seq_cfg_pkg::SEQ_IDLE;
         count_reg <= 7'h00;
         out_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         out_reg <= out_next;
      end
   end

   assign third_general_output = out_reg;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_restart_selfclr: assert property (
      restart_reg[`POS_RESTART] |=> !restart_reg[`POS_RESTART])
      else $error("restart bit did not clear itself");
   a_restart_effects: assert property (
      restart_reg[`POS_RESTART] |=> otp_reload && serial_if_reset
         && config_reg == $past(otp_image.config_val))
      else $error("restart did not reload and reset serial port");
   a_rise_zero: assert property (
      rise_edge && out3_delay_reg[3:0] == 4'h0 |=> third_general_output)
      else $error("zero rise delay did not raise output");
   a_fall_zero: assert property (
      fall_edge && out3_delay_reg[7:4] == 4'h0 |=> !third_general_output)
      else $error("zero fall delay did not lower output");
   a_rise_scale: assert property (
      rise_edge && !config_reg[`POS_DOUBLE] && !half_delay |=>
         count_reg == {2'h0, $past(out3_delay_reg[3:0]), 1'b0})
      else $error("one millisecond scaling wrong");
   a_double_scale: assert property (
      fall_edge && config_reg[`POS_DOUBLE] && !half_delay |=>
         count_reg == {1'b0, $past(out3_delay_reg[7:4]), 2'h0})
      else $error("doubled scaling wrong");
   a_no_early_rise: assert property (
      state_reg == seq_cfg_pkg::SEQ_RISE && !tick && !rise_edge
         && !fall_edge |=> $stable(third_general_output))
      else $error("output moved without a tick");
   a_pulldown_write: assert property (
      reg_req.wr && reg_req.addr == `OFS_CONFIG && !load_pending_reg
         && !restart_reg[`POS_RESTART] |=>
         pulldowns.sync_clk == $past(reg_req.wdata[`POS_SYNC_PD]))
      else $error("pulldown enables do not follow config write");
   a_thermal_sel: assert property (
      reg_req.wr && reg_req.addr == `OFS_CONFIG && !load_pending_reg
         && !restart_reg[`POS_RESTART] |=>
         thermal_warning_threshold_select == $past(reg_req.wdata[3]))
      else $error("thermal threshold select wrong");
   a_reload_pulse: assert property (
      otp_reload |=> !otp_reload && !serial_if_reset)
      else $error("restart pulses lasted more than one cycle");
   a_half_scale: assert property (
      rise_edge && !config_reg[`POS_DOUBLE] && half_delay |=>
         count_reg == {3'h0, $past(out3_delay_reg[3:0])})
      else $error("half delay scaling wrong");
   a_enable_pulldowns: assert property (
      reg_req.wr && reg_req.addr == `OFS_CONFIG && !load_pending_reg
         && !restart_reg[`POS_RESTART] |=>
         pulldowns.en3 == $past(reg_req.wdata[`POS_EN3_PULL])
         && pulldowns.en2 == $past(reg_req.wdata[`POS_EN2_PULL])
         && pulldowns.en1 == $past(reg_req.wdata[`POS_EN1_PULL]))
      else $error("enable pulldowns do not follow config write");
   a_fall_timed: assert property (
      state_reg == seq_cfg_pkg::SEQ_FALL && tick && count_reg == 7'h01
         && !rise_edge && !fall_edge |=> !third_general_output)
      else $error("delayed fall did not lower output");
endmodule

// *** rtl/seq_cfg_regs.svh ***
// Notes on behaviour
// - Output falls after enable falls, programmed delay.
// - Output rises after enable rises, programmed delay.
// - One-millisecond steps when double, half both clear or both set.
// - Restart bit restores defaults, reloads OTP, serial.
// - Restart bit clears itself after the restart.
// - Double bit selects two-millisecond steps, 30 ms, when half clear.
// - Config bit six enables sync clock pulldown.
// - Config bit four enables enable-three pulldown.
// - Config bit two enables enable-two pulldown.
// - Config bit one enables enable-one pulldown.
`ifndef SEQ_CFG_REGS_SVH
`define SEQ_CFG_REGS_SVH
`define OFS_OUT3_DELAY 8'h17
`define OFS_RESTART 8'h18
`define OFS_CONFIG 8'h19
`define RST_OUT3_DELAY 8'h00
`define RST_RESTART 8'h00
`define RST_CONFIG 8'h00
`define POS_FALL_DELAY 4
`define POS_RISE_DELAY 0
`define POS_RESTART 0
`define POS_DOUBLE 7
`define POS_SYNC_PD 6
`define POS_EN3_PULL 4
`define POS_THERM_SEL 3
`define POS_EN2_PULL 2
`define POS_EN1_PULL 1
`define CLK_PERIOD_NS 10
`define HALF_MS_TIME_US 500
`define HALF_MS_CYCLES ((`HALF_MS_TIME_US * 1000) / `CLK_PERIOD_NS)
`endif
